// ### mrb_device.sv
// Device end: decodes mode loads and sequences burst columns.
// Assumes the controller keeps the link command rules.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
module mrb_device
	import mrb_pkg::*;
#(
	parameter int PRECHARGE_CYC = (`MRB_PRECHARGE_NS * 1000 + `MRB_CLK_PS - 1) / `MRB_CLK_PS
)
(
	input wire logic nrst,
	mrb_link.dev link,
	output logic sleep_exit_select,
	output logic [2:0] recovery_cycles,
	output logic dll_reset_pulse,
	output logic factory_test_bit,
	output logic [2:0] read_latency,
	output logic burst_order_select,
	output logic burst_is_eight,
	output logic mode_bad,
	output logic bank_idle,
	output logic [4:0] autoprecharge_write_delay
);
	import mrb_pkg::*;
	mrb_state_t state; // Burst state.
	logic [2:0] start; // Starting column of the burst.
	logic [2:0] beat_idx; // Beat number inside the burst.
	logic is_write; // Burst direction.
	logic auto_pre; // Burst ends with auto precharge.
	logic [4:0] recover_cnt; // Cycles left before the bank is idle.
	logic [2:0] order_col; // Column from the ordering unit.
	logic load_hit; // Main register load this cycle.
	logic [2:0] last_beat; // Index of the final beat.
	logic new_burst; // Read or write command this cycle.
	logic same_dir; // Command matches the running burst.
	logic [2:0] wr_code; // Recovery code on the address bus.
	logic [2:0] cl_code; // Latency code on the address bus.
	logic [2:0] bl_code; // Burst size field on the address bus.

	assign load_hit = link.cmd == MRB_CMD_LOAD && link.bank == `MRB_BANK_MAIN;
	assign wr_code = link.addr[`MRB_WR_HI:`MRB_WR_LO];
	assign cl_code = link.addr[`MRB_CL_HI:`MRB_CL_LO];
	assign bl_code = link.addr[`MRB_BL_HI:`MRB_BL_LO];
	assign last_beat = burst_is_eight ? 3'h7 : 3'h3;
	assign new_burst = link.cmd == MRB_CMD_READ || link.cmd == MRB_CMD_WRITE || link.cmd == MRB_CMD_WRITE_AP;
	assign same_dir = is_write == (link.cmd != MRB_CMD_READ);

	mrb_order u_order (
		.start(start),
		.beat_idx(beat_idx),
		.eight(burst_is_eight),
		.interleave(burst_order_select),
		.col(order_col)
	);

	// Stores the mode fields on a main register load.
	always_ff @(posedge link.core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sleep_exit_select <= 1'b0;
			recovery_cycles <= 3'h2;
			factory_test_bit <= 1'b0;
			read_latency <= `MRB_CL_MIN;
			burst_order_select <= 1'b0;
			burst_is_eight <= 1'b0;
			mode_bad <= 1'b0;
		end
		else if (load_hit)
		begin
			sleep_exit_select <= link.addr[`MRB_SLEEP_BIT];
			recovery_cycles <= wr_code + `MRB_WR_OFFSET;
			factory_test_bit <= link.addr[`MRB_TEST_BIT];
			read_latency <= cl_code;
			burst_order_select <= link.addr[`MRB_ORDER_BIT];
			burst_is_eight <= bl_code == `MRB_BL8;
			// Flags a load that used a reserved code.
			mode_bad <= wr_code < `MRB_WR_MIN || wr_code > `MRB_WR_MAX || cl_code < `MRB_CL_MIN ||
				(bl_code != `MRB_BL4 && bl_code != `MRB_BL8) || link.addr[`MRB_TEST_BIT] ||
				link.addr[`MRB_A13];
		end
	end

	// Loop reset is a one-cycle pulse; a zero leaves the loop alone.
	always_ff @(posedge link.core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			dll_reset_pulse <= 1'b0;
		end
		else
		begin
			dll_reset_pulse <= load_hit && link.addr[`MRB_DLL_BIT];
		end
	end

	// Total delay from write end to idle is recovery plus precharge.
	always_ff @(posedge link.core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			autoprecharge_write_delay <= 5'h0;
		end
		else
		begin
			autoprecharge_write_delay <= 5'(recovery_cycles) + 5'(PRECHARGE_CYC);
		end
	end

	// Burst sequencer; no terminate command exists, but a same-direction command restarts an eight-beat burst early.
	always_ff @(posedge link.core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= MRB_IDLE;
			start <= 3'h0;
			beat_idx <= 3'h0;
			is_write <= 1'b0;
			auto_pre <= 1'b0;
			recover_cnt <= 5'h0;
		end
		else
		begin
			case (state)
				MRB_IDLE, MRB_RECOVER:
				begin
					if (recover_cnt != 5'h0)
					begin
						recover_cnt <= recover_cnt - 5'h1;
					end
					else if (new_burst)
					begin
						state <= MRB_BURST;
						start <= link.addr[2:0];
						beat_idx <= 3'h0;
						is_write <= link.cmd != MRB_CMD_READ;
						auto_pre <= link.cmd == MRB_CMD_WRITE_AP;
					end
					else
					begin
						state <= MRB_IDLE;
					end
				end
				MRB_BURST:
				begin
					// A command at the last beat chains on; eight-beat bursts restart early on the same direction.
					if (new_burst && (beat_idx == last_beat || (burst_is_eight && same_dir)))
					begin
						start <= link.addr[2:0];
						beat_idx <= 3'h0;
						is_write <= link.cmd != MRB_CMD_READ;
						auto_pre <= link.cmd == MRB_CMD_WRITE_AP;
					end
					else if (beat_idx == last_beat)
					begin
						state <= auto_pre ? MRB_RECOVER : MRB_IDLE;
						// The exit cycle out of recovery counts as the last delay cycle.
						recover_cnt <= auto_pre ? autoprecharge_write_delay - 5'h1 : 5'h0;
						beat_idx <= 3'h0;
					end
					else
					begin
						beat_idx <= beat_idx + 3'h1;
					end
				end
				default:
				begin
					state <= MRB_IDLE;
				end
			endcase
		end
	end

	// Drives beat column and bank idle flag from flops.
	always_ff @(posedge link.core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			link.col <= 3'h0;
			link.beat <= 1'b0;
			bank_idle <= 1'b1;
		end
		else
		begin
			link.col <= order_col;
			link.beat <= state == MRB_BURST;
			bank_idle <= state == MRB_IDLE;
		end
	end
endmodule

// ### mrb_defines.svh
// Constants for the mode register decode and burst column ordering.
// Assumes inclusion by bare name from the package and from design files.
`ifndef MRB_DEFINES_SVH
`define MRB_DEFINES_SVH
// Address and bank select bus widths.
`define MRB_ADDR_W 14
`define MRB_BANK_W 2
// Bank select value that picks the main mode register.
`define MRB_BANK_MAIN 2'h0
// Field positions inside the address word.
`define MRB_A13 13
`define MRB_SLEEP_BIT 12
`define MRB_WR_HI 11
`define MRB_WR_LO 9
`define MRB_DLL_BIT 8
`define MRB_TEST_BIT 7
`define MRB_CL_HI 6
`define MRB_CL_LO 4
`define MRB_ORDER_BIT 3
`define MRB_BL_HI 2
`define MRB_BL_LO 0
// Field encodings.
`define MRB_BL4 3'h2
`define MRB_BL8 3'h3
`define MRB_WR_MIN 3'h1
`define MRB_WR_MAX 3'h5
`define MRB_WR_OFFSET 3'h1
`define MRB_CL_MIN 3'h3
// Software port offsets.
`define MRB_REG_CTRL 4'h0
`define MRB_REG_MODE 4'h1
`define MRB_REG_STATUS 4'h2
`define MRB_REG_COLUMN 4'h3
`define MRB_REG_DEVMODE 4'h4
`define MRB_REG_TIMING 4'h5
// Control register bits.
`define MRB_CTRL_GO 0
`define MRB_CTRL_RD 1
`define MRB_CTRL_WR 2
`define MRB_CTRL_AP 3
// Timing figures in ns and the clock period in ps.
`define MRB_CLK_PS 5000
`define MRB_RECOVERY_NS 15
`define MRB_PRECHARGE_NS 15
`endif

// ### mrb_pkg.sv
// Types shared by both ends of the mode register link.
// Assumes mrb_defines.svh is on the include path.
`include "mrb_defines.svh"
package mrb_pkg;
	// Command on the link, one cycle each.
	typedef enum logic [4:0] {
		MRB_CMD_NOP = 5'h01,
		MRB_CMD_LOAD = 5'h02,
		MRB_CMD_READ = 5'h04,
		MRB_CMD_WRITE = 5'h08,
		MRB_CMD_WRITE_AP = 5'h10
	} mrb_cmd_t;
	// Device burst state.
	typedef enum logic [2:0] {
		MRB_IDLE = 3'h1,
		MRB_BURST = 3'h2,
		MRB_RECOVER = 3'h4
	} mrb_state_t;
endpackage

// ### mrb_link.sv
// Command/address link joining the controller end and the device end.
// Assumes a testbench instantiates it and the shared clock.
`timescale 1ns/1ps
interface mrb_link
	import mrb_pkg::*;
(
	input wire logic core_clk
);
	mrb_cmd_t cmd; // Command this cycle.
	logic [`MRB_BANK_W-1:0] bank; // Bank select bits.
	logic [`MRB_ADDR_W-1:0] addr; // Address bits.
	logic [2:0] col; // Column index of the current beat.
	logic beat; // High while a burst beat is on the data path.
	modport ctrl (input core_clk, output cmd, output bank, output addr, input col, input beat);
	modport dev (input core_clk, input cmd, input bank, input addr, output col, output beat);
endinterface

// ### mrb_order.sv
// Column order generator for one burst beat.
// Assumes the caller holds start, size and order stable for the burst.
`timescale 1ns/1ps
module mrb_order
(
	input wire logic [2:0] start,
	input wire logic [2:0] beat_idx,
	input wire logic eight,
	input wire logic interleave,
	output logic [2:0] col
);
	// Low pair wraps inside the aligned four; high bit flips after four beats.
	always_comb
	begin
		if (interleave)
		begin
			col = start ^ beat_idx;
		end
		else
		begin
			col[1:0] = start[1:0] + beat_idx[1:0];
			col[2] = start[2] ^ beat_idx[2];
		end
		if (!eight)
		begin
			col[2] = start[2];
		end
	end
endmodule

// ### mrb_controller.sv
// Controller end: issues mode loads and bursts from a software port.
// Assumes software writes mode values that avoid reserved codes.
`timescale 1ns/1ps
module mrb_controller
	import mrb_pkg::*;
(
	input wire logic nrst,
	mrb_link.ctrl link,
	input wire logic [3:0] sw_addr,
	input wire logic [15:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [15:0] sw_rdata
);
	import mrb_pkg::*;
	logic [`MRB_ADDR_W-1:0] mode_word; // Mode value to load.
	logic [2:0] column; // Starting column for bursts.
	logic busy; // High while command spacing or a burst beat is pending.
	logic [3:0] wait_cnt; // Spacing counter.

	// Issues at most one command per request and holds NOP otherwise.
	always_ff @(posedge link.core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			link.cmd <= MRB_CMD_NOP;
			link.bank <= `MRB_BANK_MAIN;
			link.addr <= '0;
			busy <= 1'b0;
			wait_cnt <= 4'h0;
		end
		else
		begin
			link.cmd <= MRB_CMD_NOP;
			if (wait_cnt != 4'h0)
			begin
				wait_cnt <= wait_cnt - 4'h1;
			end
			busy <= wait_cnt > 4'h1 || link.beat;
			// Bursts need only the spacing, so a same-direction burst may follow with no gap.
			if (sw_wr && sw_addr == `MRB_REG_CTRL && wait_cnt == 4'h0)
			begin
				link.bank <= `MRB_BANK_MAIN;
				if (sw_wdata[`MRB_CTRL_GO])
				begin
					// Loads also wait until the data path has drained.
					if (!busy)
					begin
						link.cmd <= MRB_CMD_LOAD;
						link.addr <= mode_word & ~(`MRB_ADDR_W'(1) << `MRB_A13);
						wait_cnt <= 4'h2;
					end
				end
				else if (sw_wdata[`MRB_CTRL_RD] || sw_wdata[`MRB_CTRL_WR])
				begin
					link.cmd <= sw_wdata[`MRB_CTRL_RD] ? MRB_CMD_READ :
						(sw_wdata[`MRB_CTRL_AP] ? MRB_CMD_WRITE_AP : MRB_CMD_WRITE);
					link.addr <= `MRB_ADDR_W'(column);
					// The next burst may land exactly as the last beat ends.
					wait_cnt <= mode_word[`MRB_BL_LO] ? 4'h7 : 4'h3;
				end
			end
		end
	end

	// Software registers: mode word with test bit forced clear, and start column.
	always_ff @(posedge link.core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mode_word <= `MRB_ADDR_W'(`MRB_BL4) | (`MRB_ADDR_W'(`MRB_CL_MIN) << `MRB_CL_LO) |
				(`MRB_ADDR_W'(`MRB_WR_MIN) << `MRB_WR_LO);
			column <= 3'h0;
		end
		else if (sw_wr && sw_addr == `MRB_REG_MODE)
		begin
			mode_word <= sw_wdata[`MRB_ADDR_W-1:0] & ~(`MRB_ADDR_W'(1) << `MRB_TEST_BIT);
		end
		else if (sw_wr && sw_addr == `MRB_REG_COLUMN)
		begin
			column <= sw_wdata[2:0];
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge link.core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sw_rdata <= 16'h0;
		end
		else if (sw_rd)
		begin
			case (sw_addr)
				`MRB_REG_MODE: sw_rdata <= 16'(mode_word);
				`MRB_REG_STATUS: sw_rdata <= {12'h0, link.col, busy};
				`MRB_REG_COLUMN: sw_rdata <= {13'h0, column};
				default: sw_rdata <= 16'h0;
			endcase
		end
		else
		begin
			sw_rdata <= 16'h0;
		end
	end
endmodule

// ### mrb_chk.sv
// Checker for the command link between the controller end and the device end.
// Assumes the bench instantiates it beside the link, on the one core clock.
`timescale 1ns/1ps
module mrb_chk
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire mrb_pkg::mrb_cmd_t cmd,
	input wire logic [1:0] bank,
	input wire logic [13:0] addr,
	input wire logic [2:0] col,
	input wire logic beat
);
	import mrb_pkg::*;
	logic eight; // Mirrored burst length is eight.
	logic ilv; // Mirrored order is interleaved.
	logic [3:0] d1; // Burst command and start, one cycle late.
	logic [3:0] d2; // Same, two cycles late: first beat is due.
	logic [2:0] base; // Start column of the burst in flight.
	logic [2:0] idx; // Beat index, zero when no burst runs.
	wire burst_cmd = cmd inside {MRB_CMD_READ, MRB_CMD_WRITE, MRB_CMD_WRITE_AP};
	wire [2:0] i_now = d2[3] ? 3'h0 : idx;
	wire [2:0] b_now = d2[3] ? d2[2:0] : base;
	wire on = d2[3] || idx != 3'h0;
	wire [2:0] exp_col = ilv ? b_now ^ i_now : {b_now[2] ^ i_now[2], b_now[1:0] + i_now[1:0]};
	// Mirrors the burst fields; only main loads count.
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			eight <= 1'b0;
			ilv <= 1'b0;
		end
		else if (cmd == MRB_CMD_LOAD && bank == 2'h0)
		begin
			eight <= addr[2:0] == 3'h3;
			ilv <= addr[3];
		end
	// Tracks which beat is expected; a new burst takes over at once.
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			d1 <= 4'h0;
			d2 <= 4'h0;
			base <= 3'h0;
			idx <= 3'h0;
		end
		else
		begin
			d1 <= {burst_cmd, addr[2:0]};
			d2 <= d1;
			base <= b_now;
			if (d2[3])
				idx <= 3'h1;
			else if (idx != 3'h0)
				idx <= (idx == (eight ? 3'h7 : 3'h3)) ? 3'h0 : idx + 3'h1;
		end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_burst;
		burst_cmd;
	endsequence
	sequence s_first;
		beat && col[1:0] == $past(addr[1:0], 2);
	endsequence
	a_beat_window: assert property (beat == on)
		else $error("beat outside burst window");
	a_seq_four: assert property (beat && !eight |-> col[1:0] == exp_col[1:0])
		else $error("four beat column wrong");
	a_seq_eight: assert property (beat && eight && !ilv |-> col == exp_col)
		else $error("eight beat sequential column wrong");
	a_ilv_eight: assert property (beat && eight && ilv |-> col == exp_col)
		else $error("eight beat interleaved column wrong");
	a_first_col: assert property (s_burst |-> ##2 s_first)
		else $error("first beat late or wrong");
	a_no_mid_four: assert property (burst_cmd && !eight |=> (cmd == MRB_CMD_NOP) [*3])
		else $error("four beat burst interrupted");
	a_rd_only_rd: assert property (cmd == MRB_CMD_READ && eight |=> (cmd inside {MRB_CMD_NOP, MRB_CMD_READ}) [*7])
		else $error("read interrupted by other command");
	a_load_idle: assert property (cmd == MRB_CMD_LOAD |-> !beat && !d2[3])
		else $error("load during burst");
	a_load_a13: assert property (cmd == MRB_CMD_LOAD && bank == 2'h0 |-> !addr[13])
		else $error("top address bit set in load");
	a_load_test: assert property (cmd == MRB_CMD_LOAD && bank == 2'h0 |-> !addr[7])
		else $error("test bit set in load");
	a_legal_cmd: assert property ($onehot(cmd))
		else $error("command not one of the set");
endmodule

// ### mrb_tb.sv
// Self-checking bench: controller and device joined by the link.
// Assumes the design files and mrb_defines.svh are compiled first.
`timescale 1ns/1ps
`include "mrb_defines.svh"
module mrb_tb;
	import mrb_pkg::*;
	localparam int PRE = 3; // Precharge cycles handed to the device.
	// Recovery cycles rounded up; one clock here, so average and nominal periods agree.
	localparam int WR_CYC = (`MRB_RECOVERY_NS * 1000 + `MRB_CLK_PS - 1) / `MRB_CLK_PS;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] sw_addr = 4'h0;
	logic [15:0] sw_wdata = 16'h0;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [15:0] sw_rdata;
	logic sleep_exit_select, dll_reset_pulse, factory_test_bit, burst_order_select;
	logic burst_is_eight, mode_bad, bank_idle;
	logic [2:0] recovery_cycles, read_latency;
	logic [4:0] autoprecharge_write_delay;
	int fail_count = 0;
	int comparisons = 0;
	mrb_link u_mrb_link (.core_clk(core_clk));
	mrb_controller u_mrb_controller (.nrst(nrst), .link(u_mrb_link.ctrl), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
	mrb_device #(.PRECHARGE_CYC(PRE)) u_mrb_device (.nrst(nrst), .link(u_mrb_link.dev),
		.sleep_exit_select(sleep_exit_select), .recovery_cycles(recovery_cycles),
		.dll_reset_pulse(dll_reset_pulse), .factory_test_bit(factory_test_bit),
		.read_latency(read_latency), .burst_order_select(burst_order_select),
		.burst_is_eight(burst_is_eight), .mode_bad(mode_bad), .bank_idle(bank_idle),
		.autoprecharge_write_delay(autoprecharge_write_delay));
	mrb_chk u_mrb_chk (.core_clk(core_clk), .nrst(nrst), .cmd(u_mrb_link.cmd), .bank(u_mrb_link.bank),
		.addr(u_mrb_link.addr), .col(u_mrb_link.col), .beat(u_mrb_link.beat));
	// Clock at 200 MHz.
	initial
		forever #2.5 core_clk = ~core_clk;
	// Counts a comparison and reports a mismatch.
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One-cycle software write; returns at the edge that takes it.
	task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge core_clk);
		sw_wr <= 1'b0;
	endtask
	// One-cycle software read; data is taken in the cycle after the strobe.
	task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
		@(posedge core_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge core_clk);
		sw_rd <= 1'b0;
		#1;
		d = sw_rdata;
	endtask
	// Loads a mode word and waits until the device fields have moved.
	task automatic load(input logic [15:0] word);
		sw_write(`MRB_REG_MODE, word);
		sw_write(`MRB_REG_CTRL, 16'h0001);
		@(posedge core_clk);
		#1;
	endtask
	// Every legal code of each stored field, decoded at the device.
	task automatic t_modes();
		for (int k = 0; k < 5; k++)
		begin
			load(16'((k % 2) << 12 | (k + 1) << 9 | (k + 3) << 4 | ((k >> 1) & 1) << 3 | 2 | (((k + 1) >> 1) & 1)));
			check("recovery", 16'(k + 2), 16'(recovery_cycles));
			check("latency", 16'(k + 3), 16'(read_latency));
			check("sleep", 16'(k % 2), 16'(sleep_exit_select));
			check("order", 16'((k >> 1) & 1), 16'(burst_order_select));
			check("eight", 16'(((k + 1) >> 1) & 1), 16'(burst_is_eight));
			check("test bit", 16'h0, 16'(factory_test_bit));
			check("bad", 16'h0, 16'(mode_bad));
			// The delay output follows the recovery field one clock later.
			@(posedge core_clk);
			#1;
			check("ap delay", 16'(k + 2 + PRE), 16'(autoprecharge_write_delay));
		end
		load(16'h0032 | 16'(WR_CYC - 1) << 9);
		check("recovery rounded", 16'(WR_CYC), 16'(recovery_cycles));
		$display("test modes done");
	endtask
	// Reserved recovery, latency and length codes are flagged.
	task automatic t_reserved();
		logic [15:0] words [7] = '{16'h0032, 16'h0c32, 16'h0e32, 16'h0202, 16'h0212, 16'h0222, 16'h0237};
		foreach (words[i])
		begin
			load(words[i]);
			check("reserved", 16'h1, 16'(mode_bad));
		end
		$display("test reserved done");
	endtask
	// Loop reset pulses once on request and not otherwise.
	task automatic t_dll();
		load(16'h0332);
		check("dll pulse", 16'h1, 16'(dll_reset_pulse));
		@(posedge core_clk);
		#1;
		check("dll end", 16'h0, 16'(dll_reset_pulse));
		load(16'h0232);
		check("dll quiet", 16'h0, 16'(dll_reset_pulse));
		$display("test dll done");
	endtask
	// One burst: every beat's column against the ordering tables.
	task automatic burst(input logic [15:0] mode, input int start, input logic [15:0] op);
		logic [2:0] s, i3, e;
		int len;
		s = 3'(start);
		len = mode[0] ? 8 : 4;
		sw_write(`MRB_REG_COLUMN, 16'(start));
		sw_write(`MRB_REG_CTRL, op);
		repeat (2) @(posedge core_clk);
		for (int i = 0; i < len; i++)
		begin
			#1;
			i3 = 3'(i);
			e = mode[3] ? s ^ i3 : {s[2] ^ i3[2], s[1:0] + i3[1:0]};
			check("beat", 16'h1, 16'(u_mrb_link.beat));
			check("column", 16'(mode[0] ? e : e[1:0]), 16'(mode[0] ? u_mrb_link.col : u_mrb_link.col[1:0]));
			@(posedge core_clk);
		end
		#1;
		check("beat end", 16'h0, 16'(u_mrb_link.beat));
	endtask
	// All starts in all four modes, reads and writes alternating.
	task automatic t_bursts();
		for (int m = 0; m < 4; m++)
		begin
			load(16'(16'h0232 | (m & 1) << 3 | (m >> 1)));
			for (int st = 0; st < 8; st++)
				burst(16'(16'h0232 | (m & 1) << 3 | (m >> 1)), st, (st % 2) ? 16'h0004 : 16'h0002);
		end
		$display("test bursts done");
	endtask
	// Second read lands exactly at the end of the first: no gap.
	task automatic t_seamless();
		load(16'h0232);
		sw_write(`MRB_REG_COLUMN, 16'h0001);
		sw_write(`MRB_REG_CTRL, 16'h0002);
		repeat (2) @(posedge core_clk);
		sw_write(`MRB_REG_CTRL, 16'h0002);
		for (int i = 0; i < 6; i++)
		begin
			#1;
			check("seamless beat", 16'h1, 16'(u_mrb_link.beat));
			@(posedge core_clk);
		end
		#1;
		check("seamless end", 16'h0, 16'(u_mrb_link.beat));
		$display("test seamless done");
	endtask
	// Write with auto precharge: bank stays busy for recovery plus precharge after the last beat.
	task automatic t_autopre();
		int dly;
		dly = 2 + PRE;
		load(16'h0232);
		sw_write(`MRB_REG_COLUMN, 16'h0000);
		sw_write(`MRB_REG_CTRL, 16'h000c);
		repeat (2) @(posedge core_clk);
		#1;
		check("busy in burst", 16'h0, 16'(bank_idle));
		repeat (4) @(posedge core_clk);
		for (int i = 0; i < dly; i++)
		begin
			#1;
			check("recovering", 16'h0, 16'(bank_idle));
			@(posedge core_clk);
		end
		#1;
		check("idle again", 16'h1, 16'(bank_idle));
		$display("test autopre done");
	endtask
	// Software registers read back; an unmapped place reads zero.
	task automatic t_regs();
		logic [15:0] d;
		sw_read(`MRB_REG_MODE, d);
		check("mode word", 16'h0232, d);
		sw_read(`MRB_REG_COLUMN, d);
		check("column reg", 16'h0001, d);
		sw_read(4'hf, d);
		check("unmapped", 16'h0, d);
		sw_read(`MRB_REG_STATUS, d);
		check("status busy", 16'h0, d & 16'h0001);
		$display("test regs done");
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence after 20 cycles of reset.
	initial
	begin
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		t_modes();
		t_reserved();
		t_dll();
		t_bursts();
		t_autopre();
		t_seamless();
		t_regs();
		close_out();
	end
	// Watchdog: the tests need a few thousand cycles at most.
	initial
	begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		close_out();
	end
endmodule
